// ==== src/vpwm_pkg.sv ====
package vpwm_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned NCH = 4;
    localparam int unsigned IDX_W = 16;
    localparam int unsigned PRD_W = 24;
    localparam int unsigned PH_W = 16;
    localparam int unsigned FS_W = 16;
    localparam int unsigned FS_FRAC = 8;
    localparam int unsigned DIV_W = 40;
    localparam int unsigned DIV_CNT_W = 6;
    localparam int unsigned TON_W = 16;
    localparam int unsigned RECIP_SH = 30;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam logic [FS_W-1:0] FS_ONE = 16'h0100;
    // index format q2.14: -1.0 and +1.0
    localparam logic signed [IDX_W-1:0] LIM_LO_DEF = 16'shc000;
    localparam logic signed [IDX_W-1:0] LIM_HI_DEF = 16'sh4000;
    localparam int unsigned F_NOM_DEF = 20000;
    localparam int unsigned TON_DELAY_NS_DEF = 100;
    localparam logic [PRD_W-1:0] PRD_MIN = 24'h000002;
    localparam logic [PRD_W-1:0] PRD_MAX = 24'hffffff;
    localparam logic [DIV_CNT_W-1:0] DIV_STEPS = 6'h28;
    localparam logic [PRD_W-1:0] CNT_RST = 24'h000000;

    typedef enum logic [1:0] {
        UPD_IMMED,
        UPD_MIN,
        UPD_MAX,
        UPD_BOTH
    } upd_mode_type;

    // least time: round up, never below one cycle
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

// ==== src/pwm_channel.sv ====
`timescale 1ns/10ps
module pwm_channel
    import vpwm_pkg::*;
#(
    parameter int unsigned TON_CYC = 1,
    parameter logic signed [IDX_W-1:0] LIM_LO = LIM_LO_DEF,
    parameter logic signed [IDX_W-1:0] LIM_HI = LIM_HI_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // period and ramp preset
    input wire logic [PRD_W-1:0] prd_in,
    input wire logic [PRD_W-1:0] prd_next_in,
    input wire logic preset_in,
    input wire logic [PH_W-1:0] phase_in,
    // configuration
    input wire logic sym_in,
    input wire upd_mode_type upd_mode_in,
    input wire logic polarity_in,
    // modulation
    input wire logic step_in,
    input wire logic signed [IDX_W-1:0] index_in,
    // outputs
    output logic wrap_out,
    output logic pwm_out
);

    // widen before subtracting: the 16-bit difference overflows
    localparam logic [IDX_W:0] SPAN = 17'(LIM_HI) - 17'(LIM_LO);
    localparam logic [31:0] RECIP = 32'((64'h1 << RECIP_SH) / SPAN);

    logic [PRD_W-1:0] cnt_q;
    logic [PRD_W-1:0] half;
    logic [PRD_W-1:0] carrier;
    logic [PRD_W-1:0] preset_v;
    logic [PRD_W-1:0] span;
    logic [PRD_W-1:0] cmp;
    logic [PRD_W+PH_W-1:0] ph_prod;
    logic [79:0] cmp_prod;
    logic signed [IDX_W:0] diff;
    logic [IDX_W:0] off;
    logic signed [IDX_W-1:0] idx_q;
    logic at_min;
    logic at_max;
    logic load;
    logic want;
    logic [TON_W-1:0] on_cnt_q;
    logic pwm_q;

    // ------------------------------------------------------------
    // carrier ramp
    // ------------------------------------------------------------
    assign half = prd_in >> 1;
    // shrinking period may leave the count above the new end
    assign wrap_out = cnt_q >= prd_in - 24'h000001;
    assign ph_prod = 40'(phase_in) * 40'(prd_next_in);
    assign preset_v = ph_prod[PH_W +: PRD_W];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= CNT_RST;
        end else if (preset_in) begin
            cnt_q <= preset_v;
        end else if (wrap_out) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
        end
    end

    always_comb begin
        carrier = cnt_q;
        if (sym_in && cnt_q > half) begin
            carrier = prd_in - cnt_q;
        end
    end

    // ------------------------------------------------------------
    // compare value update
    // ------------------------------------------------------------
    assign at_min = cnt_q == CNT_RST;
    assign at_max = sym_in && cnt_q == half;

    always_comb begin
        unique case (upd_mode_in)
            UPD_IMMED: load = step_in;
            UPD_MIN: load = at_min;
            // sawtooth has no peak: falls back to the minimum
            UPD_MAX: load = sym_in ? at_max : at_min;
            UPD_BOTH: load = at_min || at_max;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_q <= LIM_LO;
        end else if (load) begin
            idx_q <= index_in;
        end
    end

    // index kept, compare follows the period in use
    always_comb begin
        diff = 17'(idx_q) - 17'(LIM_LO);
        off = diff[IDX_W] ? 17'h00000 : 17'(diff);
        if (off > SPAN) begin
            off = SPAN;
        end
        span = sym_in ? half : prd_in;
        cmp_prod = 80'(off) * 80'(span) * 80'(RECIP);
        cmp = cmp_prod[RECIP_SH +: PRD_W];
    end

    // ------------------------------------------------------------
    // output with turn-on delay
    // ------------------------------------------------------------
    assign want = (cmp > carrier) ^ polarity_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            on_cnt_q <= 16'h0000;
            pwm_q <= 1'b0;
        end else if (!want) begin
            on_cnt_q <= 16'h0000;
            pwm_q <= 1'b0;
        end else if (!pwm_q) begin
            if (on_cnt_q == TON_W'(TON_CYC)) begin
                pwm_q <= 1'b1;
            end else begin
                on_cnt_q <= on_cnt_q + 16'h0001;
            end
        end
    end

    assign pwm_out = pwm_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_wrap;
        wrap_out && !preset_in |=> cnt_q == 24'h000000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("ramp did not return to zero");

    property p_rise;
        !wrap_out && !preset_in |=> cnt_q == $past(cnt_q) + 24'h000001;
    endproperty
    a_rise: assert property (p_rise)
        else $error("ramp did not step by one");

    property p_sym;
        sym_in |-> carrier <= half;
    endproperty
    a_sym: assert property (p_sym)
        else $error("symmetrical carrier above peak");

    property p_preset;
        preset_in |=> cnt_q == $past(preset_v);
    endproperty
    a_preset: assert property (p_preset)
        else $error("slave preset missed");

    property p_cmp;
        cmp <= span;
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare value out of range");

    property p_load_min;
        upd_mode_in == UPD_MIN && at_min |=> idx_q == $past(index_in);
    endproperty
    a_load_min: assert property (p_load_min)
        else $error("index not taken at minimum");

    property p_off;
        !want |=> !pwm_out;
    endproperty
    a_off: assert property (p_off)
        else $error("output not off");

    property p_ton;
        $rose(pwm_out) |-> $past(on_cnt_q) == TON_W'(TON_CYC);
    endproperty
    a_ton: assert property (p_ton)
        else $error("turn-on delay wrong");

    c_rise: cover property ($rose(pwm_out));
    c_peak: cover property (at_max && load);

endmodule

// ==== src/variable_pwm_generator.sv ====
`timescale 1ns/10ps
module variable_pwm_generator
    import vpwm_pkg::*;
#(
    parameter int unsigned F_NOM_HZ = F_NOM_DEF,
    parameter int unsigned TON_DELAY_NS = TON_DELAY_NS_DEF,
    parameter logic signed [IDX_W-1:0] LIM_LO = LIM_LO_DEF,
    parameter logic signed [IDX_W-1:0] LIM_HI = LIM_HI_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,

    // model step data
    input wire logic step_in,
    input wire logic [NCH-1:0][IDX_W-1:0] index_in,
    input wire logic [FS_W-1:0] frequency_scale_in,
    input wire logic [NCH-1:0][PH_W-1:0] phase_delay_in,

    // configuration
    input wire logic sym_in,
    input wire upd_mode_type upd_mode_in,
    input wire logic sync_en_in,
    input wire logic pol_per_ch_in,
    input wire logic pol_all_in,
    input wire logic [NCH-1:0] pol_vec_in,

    // outputs
    output logic [NCH-1:0] pwm_out,
    output logic [PRD_W-1:0] period_count_out,
    output logic locked_out
);

    localparam int unsigned TON_CYC = ns_to_cyc(TON_DELAY_NS);
    localparam logic [PRD_W-1:0] PRD_RST = PRD_W'(CLK_HZ / F_NOM_HZ);
    localparam logic [DIV_W-1:0] CLK_NUM = DIV_W'(CLK_HZ) << FS_FRAC;

    typedef enum logic [1:0] {
        DIV_START,
        DIV_RAW,
        DIV_K,
        DIV_SYNC
    } div_state_type;

    // ------------------------------------------------------------
    // model step period measurement
    // ------------------------------------------------------------
    logic [DIV_W-1:0] step_cnt_q;
    logic [DIV_W-1:0] step_cyc_q;
    logic [1:0] step_seen_q;
    logic step_valid;
    logic lock;

    assign step_valid = step_seen_q[1];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_cnt_q <= '0;
            step_cyc_q <= '0;
            step_seen_q <= 2'h0;
        end else if (step_in) begin
            step_cnt_q <= '0;
            step_cyc_q <= step_cnt_q + 40'h0000000001;
            step_seen_q <= {step_seen_q[0], 1'b1};
        end else begin
            step_cnt_q <= step_cnt_q + 40'h0000000001;
        end
    end

    // realign on a step once the step length is known
    assign lock = sync_en_in && step_in && step_valid;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            locked_out <= 1'b0;
        end else if (!sync_en_in) begin
            locked_out <= 1'b0;
        end else if (lock) begin
            locked_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // period computation
    // ------------------------------------------------------------
    // one serial divider reused up to three times (once unless synced): cheaper than
    // parallel dividers, period value trails the inputs a bit
    div_state_type div_st_q;
    logic [DIV_W-1:0] num_q;
    logic [DIV_W-1:0] den_q;
    logic [DIV_W:0] rem_q;
    logic [DIV_W-1:0] quo_q;
    logic [DIV_CNT_W-1:0] bits_q;
    logic [DIV_W:0] rem_sh;
    logic div_done;
    logic [PRD_W-1:0] quo_sat;
    logic [PRD_W-1:0] prd_next_q;
    logic [DIV_W-1:0] freq_den;

    function automatic logic [PRD_W-1:0] sat_prd(
        input logic [DIV_W-1:0] q
    );
        if (q > DIV_W'(PRD_MAX)) begin
            return PRD_MAX;
        end
        if (q < DIV_W'(PRD_MIN)) begin
            return PRD_MIN;
        end
        return q[PRD_W-1:0];
    endfunction

    assign rem_sh = {rem_q[DIV_W-1:0], num_q[DIV_W-1]};
    assign div_done = bits_q == 6'h00;
    assign quo_sat = sat_prd(quo_q);
    // nominal frequency times scale, scale has FS_FRAC fraction bits
    assign freq_den = DIV_W'(F_NOM_HZ) * DIV_W'(frequency_scale_in);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_st_q <= DIV_START;
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            quo_q <= '0;
            bits_q <= 6'h00;
            prd_next_q <= PRD_RST;
        end else if (!div_done) begin
            // restoring division, one quotient bit per cycle
            num_q <= num_q << 1;
            if (rem_sh >= {1'b0, den_q}) begin
                rem_q <= rem_sh - {1'b0, den_q};
                quo_q <= {quo_q[DIV_W-2:0], 1'b1};
            end else begin
                rem_q <= rem_sh;
                quo_q <= {quo_q[DIV_W-2:0], 1'b0};
            end
            bits_q <= bits_q - 6'h01;
        end else begin
            rem_q <= '0;
            quo_q <= '0;
            bits_q <= DIV_STEPS;
            unique case (div_st_q)
                DIV_START: begin
                    // rounded: add half the divisor
                    num_q <= CLK_NUM + (freq_den >> 1);
                    den_q <= freq_den;
                    div_st_q <= DIV_RAW;
                end
                DIV_RAW: begin
                    if (sync_en_in && step_valid) begin
                        // periods per step, rounded
                        num_q <= step_cyc_q + DIV_W'(quo_sat >> 1);
                        den_q <= DIV_W'(quo_sat);
                        div_st_q <= DIV_K;
                    end else begin
                        prd_next_q <= quo_sat;
                        bits_q <= 6'h00;
                        div_st_q <= DIV_START;
                    end
                end
                DIV_K: begin
                    // at least one period per step
                    if (quo_q == '0) begin
                        num_q <= step_cyc_q;
                        den_q <= 40'h0000000001;
                    end else begin
                        num_q <= step_cyc_q + (quo_q >> 1);
                        den_q <= quo_q;
                    end
                    div_st_q <= DIV_SYNC;
                end
                DIV_SYNC: begin
                    prd_next_q <= quo_sat;
                    bits_q <= 6'h00;
                    div_st_q <= DIV_START;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // master, slaves and period update
    // ------------------------------------------------------------
    logic [NCH-1:0] wrap;
    logic [NCH-1:0] preset;
    logic [NCH-1:0] pol;
    logic master_sync;
    logic [PRD_W-1:0] prd_q;
    logic [PRD_W-1:0] prd_d;

    // channel 0 is the master
    assign master_sync = wrap[0] || lock;

    assign prd_d = master_sync ? prd_next_q : prd_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prd_q <= PRD_RST;
        end else begin
            prd_q <= prd_d;
        end
    end

    assign period_count_out = prd_q;

    // master only presets on a lock, slaves on every sync
    always_comb begin
        preset = {NCH{master_sync}};
        preset[0] = lock;
    end

    assign pol = pol_per_ch_in ? pol_vec_in : {NCH{pol_all_in}};

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        pwm_channel #(
            .TON_CYC(TON_CYC),
            .LIM_LO(LIM_LO),
            .LIM_HI(LIM_HI)
        ) u_ch (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .prd_in(prd_q),
            .prd_next_in(prd_d),
            .preset_in(preset[i]),
            .phase_in(phase_delay_in[i]),
            .sym_in(sym_in),
            .upd_mode_in(upd_mode_in),
            .polarity_in(pol[i]),
            .step_in(step_in),
            .index_in(index_in[i]),
            .wrap_out(wrap[i]),
            .pwm_out(pwm_out[i])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_prd_hold;
        !master_sync |=> $stable(period_count_out);
    endproperty
    a_prd_hold: assert property (p_prd_hold)
        else $error("period changed outside master sync");

    property p_prd_take;
        master_sync |=> period_count_out == $past(prd_next_q);
    endproperty
    a_prd_take: assert property (p_prd_take)
        else $error("period not applied at master sync");

    property p_slave_sync;
        master_sync |=> g_ch[NCH-1].u_ch.cnt_q == PRD_W'(
            (40'($past(phase_delay_in[NCH-1])) * 40'(period_count_out))
            >> PH_W);
    endproperty
    a_slave_sync: assert property (p_slave_sync)
        else $error("slaves not synced by master");

    property p_master_free;
        wrap[0] && !lock |=> g_ch[0].u_ch.cnt_q == CNT_RST;
    endproperty
    a_master_free: assert property (p_master_free)
        else $error("master preset without lock");

    property p_lock;
        lock |=> locked_out;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock not flagged");

    property p_prd_range;
        prd_next_q >= PRD_MIN;
    endproperty
    a_prd_range: assert property (p_prd_range)
        else $error("period below minimum");

    c_sync: cover property (wrap[0] ##1 !wrap[0]);
    c_lock: cover property (lock);
    c_prd_change: cover property (master_sync && prd_next_q != prd_q);

endmodule

// ==== bench/vpwm_source.sv ====
`timescale 1ns/10ps
module vpwm_source (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // step control
    input wire logic en_in,
    input wire logic [15:0] step_cyc_in,
    // model step strobe
    output logic step_out
);
    // ----------------------------------------------------------
    // model step timer
    // ----------------------------------------------------------
    logic [15:0] cnt_q;

    // one block only, so cross-block phase needs nothing more
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
            step_out <= 1'b0;
        end else if (en_in && cnt_q + 16'h0001 >= step_cyc_in) begin
            cnt_q <= 16'h0000;
            step_out <= 1'b1;
        end else begin
            cnt_q <= en_in ? cnt_q + 16'h0001 : cnt_q;
            step_out <= 1'b0;
        end
    end
endmodule

// ==== bench/variable_pwm_generator_tb.sv ====
`timescale 1ns/10ps
module variable_pwm_generator_tb
    import vpwm_pkg::*;
();
    // ----------------------------------------------------------
    // setup
    // ----------------------------------------------------------
    // short carrier keeps the run small: 100 cycles nominal
    localparam int F_NOM = 500000;
    localparam int TON_NS = 100;
    localparam int TON = TON_NS / 20;
    localparam int NPER = 4;
    localparam int STEP_L = 1030;
    logic clk_in = 1'b0;
    logic rst_n_in;
    logic step;
    logic src_en;
    logic [15:0] step_cyc;
    logic [NCH-1:0][IDX_W-1:0] index_in;
    logic [NCH-1:0][IDX_W-1:0] hold;
    logic [FS_W-1:0] frequency_scale_in;
    logic [NCH-1:0][PH_W-1:0] phase_delay_in;
    logic sym_in;
    upd_mode_type upd_mode_in;
    logic sync_en_in;
    logic pol_per_ch_in;
    logic pol_all_in;
    logic [NCH-1:0] pol_vec_in;
    logic [NCH-1:0] pwm_out;
    logic [PRD_W-1:0] period_count_out;
    logic locked_out;
    logic [15:0] lfsr_q = 16'h004d;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int meas_n = 0;
    int hi [NCH] = '{default: 0};
    int exp_q [$];
    int p;
    int k2;

    variable_pwm_generator #(.F_NOM_HZ(F_NOM), .TON_DELAY_NS(TON_NS))
    u_variable_pwm_generator (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .step_in(step),
        .index_in(index_in), .frequency_scale_in(frequency_scale_in),
        .phase_delay_in(phase_delay_in), .sym_in(sym_in),
        .upd_mode_in(upd_mode_in), .sync_en_in(sync_en_in),
        .pol_per_ch_in(pol_per_ch_in), .pol_all_in(pol_all_in),
        .pol_vec_in(pol_vec_in), .pwm_out(pwm_out),
        .period_count_out(period_count_out), .locked_out(locked_out)
    );

    vpwm_source u_vpwm_source (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(src_en),
        .step_cyc_in(step_cyc), .step_out(step)
    );

    always #10 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------
    // checking
    // ----------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic int raw_prd(input int s);
        longint num;
        longint den;
        num = longint'(CLK_HZ) * 256;
        den = longint'(F_NOM) * s;
        return int'((num + den / 2) / den);
    endfunction

    // cycles high per carrier period
    function automatic int exp_hi(input logic signed [15:0] ix,
        input int pr, input logic s, input logic pl);
        int off;
        int cmp;
        int b;
        off = int'(ix) - int'(LIM_LO_DEF);
        off = (off < 0) ? 0 : (off > 32768) ? 32768 : off;
        cmp = off * (s ? pr / 2 : pr) / 32768;
        b = s ? ((cmp == 0) ? 0 : 2 * cmp - 1) : cmp;
        b = pl ? pr - b : b;
        // a full-period pulse never rises, so loses no delay
        return (b <= 0) ? 0 : (b >= pr) ? pr : b - TON;
    endfunction

    task automatic check_val(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic check_hi(input int got, input int want);
        check_val(got, want);
    endtask

    // sampled mid-cycle, away from the edge that moves the outputs
    always @(negedge clk_in) begin
        if (meas_n > 0) begin
            for (int i = 0; i < NCH; i++)
                hi[i] += (pwm_out[i] === 1'b1) ? 1 : 0;
            meas_n--;
            if (meas_n == 0) begin
                for (int i = 0; i < NCH; i++) begin
                    check_hi(hi[i], exp_q.pop_front());
                    hi[i] = 0;
                end
            end
        end
    end

    task automatic measure(input logic [NCH-1:0][IDX_W-1:0] ix, input int pr);
        repeat (3 * pr) @(negedge clk_in);
        for (int i = 0; i < NCH; i++)
            exp_q.push_back(NPER * exp_hi(ix[i], pr, sym_in,
                pol_per_ch_in ? pol_vec_in[i] : pol_all_in));
        meas_n = NPER * pr;
        while (meas_n > 0)
            @(negedge clk_in);
    endtask

    task automatic wait_prd(input int want);
        for (int k = 0; k < 2000; k++)
            if (period_count_out !== PRD_W'(want))
                @(negedge clk_in);
        check_val({8'h00, period_count_out}, want);
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        src_en = 1'b0;
        step_cyc = 16'h0046;
        index_in = '0;
        frequency_scale_in = FS_ONE;
        phase_delay_in = '0;
        sym_in = 1'b0;
        upd_mode_in = UPD_IMMED;
        sync_en_in = 1'b0;
        pol_per_ch_in = 1'b0;
        pol_all_in = 1'b0;
        pol_vec_in = '0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        check_val({28'h0, pwm_out}, 32'h0);
        check_val({8'h00, period_count_out}, CLK_HZ / F_NOM);
        check_val({31'h0, locked_out}, 32'h0);
        rst_n_in = 1'b1;
        src_en = 1'b1;
        p = raw_prd(256);
        // every carrier shape with every load point
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_in);
            for (int i = 0; i < NCH; i++) begin
                lfsr_q = lfsr_next(lfsr_q);
                index_in[i] = LIM_LO_DEF + 16'h1000 + {2'h0, lfsr_q[13:0]};
                phase_delay_in[i] = lfsr_q ^ 16'h5a5a;
                pol_vec_in[i] = lfsr_q[15];
            end
            pol_all_in = lfsr_q[14];
            pol_per_ch_in = k[0];
            sym_in = k[2];
            upd_mode_in = upd_mode_type'(k[1:0]);
            measure(index_in, p);
        end
        // without a model step the immediate mode keeps the old value
        upd_mode_in = UPD_IMMED;
        sym_in = 1'b0;
        repeat (3 * p) @(negedge clk_in);
        src_en = 1'b0;
        hold = index_in;
        repeat (2) @(negedge clk_in);
        index_in = ~hold;
        measure(hold, p);
        src_en = 1'b1;
        measure(index_in, p);
        // indices beyond the limits clamp
        index_in = {NCH{16'h7fff}};
        measure(index_in, p);
        index_in = {NCH{16'h8000}};
        measure(index_in, p);
        index_in = '0;
        for (int k = 0; k < 3; k++) begin
            frequency_scale_in = (k == 0) ? 16'h0200 :
                (k == 1) ? 16'h0080 : FS_ONE;
            p = raw_prd(int'(frequency_scale_in));
            wait_prd(p);
            measure(index_in, p);
        end
        // locking rounds the period to fit the model step
        step_cyc = 16'(STEP_L);
        sync_en_in = 1'b1;
        k2 = (STEP_L + p / 2) / p;
        k2 = (STEP_L + k2 / 2) / k2;
        for (int k = 0; k < 8000; k++)
            if (locked_out !== 1'b1 || period_count_out !== PRD_W'(k2))
                @(negedge clk_in);
        check_val({31'h0, locked_out}, 32'h1);
        check_val({8'h00, period_count_out}, k2);
        sync_en_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check_val({31'h0, locked_out}, 32'h0);
        test_done();
    end
endmodule
